// *** logic/ncps_top.v ***
// Oscillator phase sync, reference divisor and phase accumulator
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ncps_consts.vh"

// What this block does
// - Divisor zero bypasses it; plain 32-bit phase accumulator from frequency word.
// - One 16-bit divisor value serves every oscillator preset.
// - Link-request bit set: reset phase at first boundary after link request rise.
// - Link-request phase init works for both 8B/10B and 64B/66B coding.
// - In 64B/66B, link request only aligns phase, not link control.
// - Writing arm bit zero then one arms; next SYSREF rise inits phase.
// - After SYSREF init, later edges ignored until rearmed by zero then one.
// - Source pulses SYSREF; armed device inits phase on first rising edge.
// - 16-bit phase offset is left justified into 32 bits and added.
module ncps_top (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // AXI4-Lite write address
    input  wire [13:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [13:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // Link side pins (asynchronous)
    input  wire        link_sync_n,
    input  wire        sysref,
    // Link configuration and timing from link logic
    input  wire        link_coding,
    input  wire        frame_boundary,
    // Link request seen by link control (8B/10B only)
    output wire        link_request_to_link,
    // Oscillator outputs
    output wire [31:0] nco_phase,
    output wire        phase_init_pulse
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire sync_lvl;
    wire sync_rise;
    wire sref_rise;

    ncps_edge_sync #(.IDLE_LVL(`NCPS_IDLE_LINK_SYNC)) u_sync_req (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (link_sync_n),
        .level    (sync_lvl),
        .rise     (sync_rise)
    );

    ncps_edge_sync #(.IDLE_LVL(`NCPS_IDLE_SYSREF)) u_sync_sref (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (sysref),
        .level    (),
        .rise     (sref_rise)
    );

    // 64B/66B: link request hidden from link control
    assign link_request_to_link = (link_coding == `NCPS_CODE_64B66B) ? 1'b1 : sync_lvl;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    reg [15:0] ref_div_r;
    reg [7:0]  sync_ctl_r;
    reg [31:0] freq_word_r;
    reg [15:0] phase_off_r;
    reg        aw_hold_r;
    reg [13:0] aw_addr_r;
    reg        w_hold_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;
    reg        bvalid_r;
    reg [1:0]  bresp_r;
    reg        rvalid_r;
    reg [1:0]  rresp_r;
    reg [31:0] rdata_r;
    reg        armed_r;
    reg        link_pend_r;
    reg        init_r;
    reg [31:0] acc_r;

    assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
    assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    wire        aw_fire = s_axi_awvalid & s_axi_awready;
    wire        w_fire  = s_axi_wvalid & s_axi_wready;
    wire        have_aw = aw_hold_r | aw_fire;
    wire        have_w  = w_hold_r | w_fire;
    wire [13:0] wa      = aw_hold_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wd      = w_hold_r ? w_data_r : s_axi_wdata;
    wire [3:0]  ws      = w_hold_r ? w_strb_r : s_axi_wstrb;
    wire        do_wr   = have_aw & have_w;
    wire [11:0] widx    = wa[13:2];
    wire [11:0] ridx    = s_axi_araddr[13:2];
    wire        ar_fire = s_axi_arvalid & s_axi_arready;

    wire wr_rdiv  = do_wr & (widx == `NCPS_IDX_RDIV);
    wire wr_sync  = do_wr & (widx == `NCPS_IDX_SYNC);
    wire wr_freq  = do_wr & (widx == `NCPS_IDX_FREQ);
    wire wr_phase = do_wr & (widx == `NCPS_IDX_PHASE);
    wire wr_ok    = wr_rdiv | wr_sync | wr_freq | wr_phase;

    // Byte-lane merge
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  st;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (st[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    wire [31:0] sync_new  = merge({24'h00_0000, sync_ctl_r}, wd, ws);
    wire [31:0] rdiv_new  = merge({16'h0000, ref_div_r}, wd, ws);
    wire [31:0] phase_new = merge({16'h0000, phase_off_r}, wd, ws);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_hold_r   <= 1'b0;
            aw_addr_r   <= 14'h0000;
            w_hold_r    <= 1'b0;
            w_data_r    <= 32'h0000_0000;
            w_strb_r    <= 4'h0;
            bvalid_r    <= 1'b0;
            bresp_r     <= `NCPS_RESP_OKAY;
            ref_div_r   <= `NCPS_RST_RDIV;
            sync_ctl_r  <= `NCPS_RST_SYNC;
            freq_word_r <= `NCPS_RST_FREQ;
            phase_off_r <= `NCPS_RST_PHASE;
        end else begin
            if (aw_fire & ~do_wr) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_fire & ~do_wr) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_ok ? `NCPS_RESP_OKAY : `NCPS_RESP_SLVERR;
            end else if (bvalid_r & s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (wr_rdiv) begin
                ref_div_r <= rdiv_new[15:0];
            end
            if (wr_sync) begin
                sync_ctl_r <= sync_new[7:0];
            end
            if (wr_freq) begin
                freq_word_r <= merge(freq_word_r, wd, ws);
            end
            if (wr_phase) begin
                phase_off_r <= phase_new[15:0];
            end
        end
    end

    // Read path
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rresp_r  <= `NCPS_RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= `NCPS_RESP_OKAY;
            case (ridx)
                `NCPS_IDX_RDIV:   rdata_r <= {16'h0000, ref_div_r};
                `NCPS_IDX_SYNC:   rdata_r <= {24'h00_0000, sync_ctl_r};
                `NCPS_IDX_FREQ:   rdata_r <= freq_word_r;
                `NCPS_IDX_PHASE:  rdata_r <= {16'h0000, phase_off_r};
                `NCPS_IDX_STATUS: rdata_r <= {29'h0000_0000, link_pend_r, armed_r, sync_lvl};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= `NCPS_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r & s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Phase initialisation control
    // ------------------------------------------------------------
    wire link_init_en = sync_ctl_r[`NCPS_BIT_LINK_INIT];
    wire arm_bit      = sync_ctl_r[`NCPS_BIT_SYS_ARM];
    // Arm on a write that turns the bit from zero to one
    wire arm_write    = wr_sync & ~arm_bit & sync_new[`NCPS_BIT_SYS_ARM];
    wire disarm_write = wr_sync & ~sync_new[`NCPS_BIT_SYS_ARM];
    // Both codings share the same boundary-based trigger
    wire link_fire    = link_pend_r & frame_boundary;
    wire sref_fire    = armed_r & sref_rise;
    wire init_now     = link_fire | sref_fire;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            armed_r     <= 1'b0;
            link_pend_r <= 1'b0;
            init_r      <= 1'b0;
        end else begin
            if (arm_write) begin
                armed_r <= 1'b1;
            end else if (sref_fire | disarm_write) begin
                armed_r <= 1'b0;
            end
            if (link_init_en & sync_rise) begin
                link_pend_r <= 1'b1;
            end else if (link_fire | ~link_init_en) begin
                link_pend_r <= 1'b0;
            end
            init_r <= init_now;
        end
    end

    assign phase_init_pulse = init_r;

    // ------------------------------------------------------------
    // Phase accumulator
    // ------------------------------------------------------------
    // Divisor zero: plain accumulator. Otherwise wrap modulo 2^25*divisor.
    wire [40:0] modulus = {ref_div_r, 25'h000_0000};
    reg  [40:0] racc_r;
    wire [40:0] racc_sum = racc_r + {9'h000, freq_word_r};
    wire [40:0] racc_nxt = (racc_sum >= modulus) ? (racc_sum - modulus) : racc_sum;
    wire [31:0] offset32 = {phase_off_r, 16'h0000};
    wire [31:0] frac_ph;
    // Residue over 2^25*divisor, scaled to 32 bits: racc*2^7/divisor
    wire [47:0] scaled = {racc_r, 7'h00} / {32'h0000_0000, ref_div_r | 16'h0001};

    assign frac_ph = (ref_div_r == 16'h0000) ? acc_r : scaled[31:0];

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_r  <= 32'h0000_0000;
            racc_r <= 41'h000_0000_0000;
        end else if (init_now) begin
            acc_r  <= 32'h0000_0000;
            racc_r <= 41'h000_0000_0000;
        end else begin
            acc_r  <= acc_r + freq_word_r;
            racc_r <= (ref_div_r == 16'h0000) ? 41'h000_0000_0000 : racc_nxt;
        end
    end

    reg [31:0] phase_r;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase_r <= 32'h0000_0000;
        end else begin
            phase_r <= frac_ph + offset32;
        end
    end
    assign nco_phase = phase_r;
endmodule // ncps_top
`default_nettype wire

// *** logic/ncps_consts.vh ***
// Constants for the oscillator phase sync and reference divisor block
`ifndef NCPS_CONSTS_VH
`define NCPS_CONSTS_VH

// Register indices (printed offsets, not all multiples of four)
`define NCPS_IDX_RDIV        12'h0217
`define NCPS_IDX_SYNC        12'h0219
`define NCPS_IDX_FREQ        12'h0220
`define NCPS_IDX_PHASE       12'h0224
`define NCPS_IDX_STATUS      12'h0300
// Reset values
`define NCPS_RST_RDIV        16'h0000
`define NCPS_RST_SYNC        8'h02
`define NCPS_RST_FREQ        32'hc000_0000
`define NCPS_RST_PHASE       16'h0000
// Idle levels the pin synchronisers reset to
`define NCPS_IDLE_LINK_SYNC  1'b1
`define NCPS_IDLE_SYSREF     1'b0
// Field positions of the phase sync control register
`define NCPS_BIT_LINK_INIT   1
`define NCPS_BIT_SYS_ARM     0
// Link coding select
`define NCPS_CODE_8B10B      1'b0
`define NCPS_CODE_64B66B     1'b1
// AXI responses
`define NCPS_RESP_OKAY       2'b00
`define NCPS_RESP_SLVERR     2'b10

`endif

// *** logic/ncps_edge_sync.v ***
// Two-flop synchroniser with rising edge detect
`timescale 1ns/1ps
`default_nettype none
module ncps_edge_sync #(
    // Pin level while idle; reset to it so no false edge follows reset
    parameter [0:0] IDLE_LVL = 1'b0
) (
    // Clock and reset
    input  wire clk_sys,
    input  wire rst,
    // Asynchronous input
    input  wire async_in,
    // Synchronised level and rising edge pulse
    output wire level,
    output wire rise
);
    reg meta_r;
    reg sync_r;
    reg prev_r;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_r <= IDLE_LVL;
            sync_r <= IDLE_LVL;
            prev_r <= IDLE_LVL;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
endmodule // ncps_edge_sync
`default_nettype wire

// *** tb/ncps_properties.sv ***
// Protocol and phase-init checker for the oscillator sync block
`timescale 1ns/1ps
`default_nettype none
`include "ncps_consts.vh"
module ncps_properties (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Link and oscillator
    input wire logic        link_sync_n,
    input wire logic        sysref,
    input wire logic        link_coding,
    input wire logic        frame_boundary,
    input wire logic        link_request_to_link,
    input wire logic        phase_init_pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [3:0] age_r;
    logic       sys_q_r;
    // Cycles since the last raw sysref rise or frame boundary
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            age_r   <= 4'hf;
            sys_q_r <= 1'b0;
        end else begin
            sys_q_r <= sysref;
            if ((sysref && !sys_q_r) || frame_boundary) age_r <= 4'h0;
            else if (age_r != 4'hf) age_r <= age_r + 4'h1;
        end
    end
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready while response pending");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while data pending");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write response late");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
    a_link_ignored: assert property (link_coding |-> link_request_to_link)
        else $error("link request reached link control in 64b66b");
    a_link_level: assert property (!link_coding && link_sync_n == $past(link_sync_n)
        && link_sync_n == $past(link_sync_n, 2) && link_sync_n == $past(link_sync_n, 3)
        |-> link_request_to_link == link_sync_n) else $error("link request level wrong");
    a_pulse_single: assert property (phase_init_pulse |=> !phase_init_pulse)
        else $error("init pulse longer than one cycle");
    a_init_cause: assert property (phase_init_pulse |-> age_r <= 4'h7)
        else $error("phase init without a recent edge or boundary");
    cover property (phase_init_pulse && link_coding);
    cover property (phase_init_pulse && !link_coding);
    cover property (s_axi_bvalid && s_axi_bresp == `NCPS_RESP_SLVERR);
endmodule // ncps_properties
`default_nettype wire

// *** tb/ncps_link_model.sv ***
// Link receiver and sysref source model
`timescale 1ns/1ps
`default_nettype none
module ncps_link_model (
    // Clock and reset
    input wire logic  clk_sys,
    input wire logic  rst,
    // Far side signals
    output var logic  sysref,
    output var logic  link_sync_n,
    output var logic  frame_boundary
);
    logic [3:0] fcnt_r;
    initial begin
        sysref = 1'b0;
        link_sync_n = 1'b1;
    end
    // Frame boundary every 16 cycles
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fcnt_r <= 4'h0;
            frame_boundary <= 1'b0;
        end else begin
            fcnt_r <= fcnt_r + 4'h1;
            frame_boundary <= (fcnt_r == 4'hf);
        end
    end
    // Sysref idle low except inside these pulses
    task automatic pulse_sysref(input int n);
        repeat (n) begin
            @(posedge clk_sys) sysref <= 1'b1;
            repeat (4) @(posedge clk_sys);
            sysref <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
    endtask
    task automatic set_sync(input logic v);
        @(posedge clk_sys) link_sync_n <= v;
    endtask
endmodule // ncps_link_model
`default_nettype wire

// *** tb/nco_phase_sync_and_divisor_tb_top.sv ***
// Self-checking bench for the oscillator sync block
`timescale 1ns/1ps
`default_nettype none
`include "ncps_consts.vh"
module nco_phase_sync_and_divisor_tb_top;
    typedef struct {logic w; logic [13:0] a; logic [31:0] d, e; logic [3:0] s; logic [1:0] r;} ncps_row_t;
    logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, link_sync_n, sysref, link_coding, frame_boundary;
    logic        link_request_to_link, phase_init_pulse;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, nco_phase, d, p0;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          n_fail, n_checks, n_init, k, j;
    localparam logic [13:0] RDIV = 14'h085C, SYNC = 14'h0864, FREQ = 14'h0880, OFS = 14'h0890;
    localparam logic [13:0] STAT = 14'h0C00;
    localparam logic [31:0] OFF = 32'h1234_0000;
    ncps_row_t rows[8] = '{
        '{0, RDIV, 0, 0, 4'hf, 0}, '{0, SYNC, 0, `NCPS_RST_SYNC, 4'hf, 0},
        '{0, FREQ, 0, `NCPS_RST_FREQ, 4'hf, 0}, '{0, OFS, 0, 0, 4'hf, 0},
        '{1, RDIV, 32'hffff_2000, 32'h0000_2000, 4'hf, 0},
        '{1, RDIV, 32'h0000_10ff, 32'h0000_1000, 4'h2, 0},
        '{1, RDIV, 0, 0, 4'hf, 0}, '{1, 14'h0004, 1, 0, 4'hf, `NCPS_RESP_SLVERR}};
    ncps_top dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .link_sync_n, .sysref, .link_coding, .frame_boundary,
        .link_request_to_link, .nco_phase, .phase_init_pulse);
    ncps_link_model far (.clk_sys, .rst, .sysref, .link_sync_n, .frame_boundary);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (phase_init_pulse === 1'b1) n_init <= n_init + 1;
    task automatic report_and_stop;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tmo(input int i);
        if (i >= 100) begin
            n_fail++;
            $display("[FAIL] %0t bus wait ran out", $time);
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
        int i;
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (i = 0; i < 100; i++) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        tmo(i);
    endtask
    task automatic rd(input logic [13:0] a);
        int i;
        @(posedge clk_sys);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        for (i = 0; i < 100; i++) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                {d, r} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'b0;
                break;
            end
        end
        tmo(i);
    endtask
    task automatic spin_and_wait(input int n);
        wr(FREQ, 1);
        wr(FREQ, 0);
        k = n_init;
        if (n > 0) far.pulse_sysref(n);
        else far.set_sync(1'b1);
        for (int i = 0; i < 60 && n_init == k; i++) @(posedge clk_sys);
        repeat (4) @(negedge clk_sys);
    endtask
    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h21;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, link_coding} = '0;
        {n_fail, n_checks} = '0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].s);
            if (rows[i].w) chk(r, rows[i].r);
            rd(rows[i].a);
            chk(d, rows[i].e);
            chk(r, rows[i].r);
        end
        $display("register table done");
        @(negedge clk_sys) p0 = nco_phase;
        @(negedge clk_sys) chk(nco_phase - p0, `NCPS_RST_FREQ);
        wr(FREQ, 0);
        @(negedge clk_sys) p0 = nco_phase;
        wr(OFS, 32'h0000_1234);
        repeat (2) @(negedge clk_sys);
        chk(nco_phase - p0, OFF);
        $display("accumulator and offset done");
        for (j = 0; j < 3; j++) begin
            if (j != 1) wr(SYNC, 0);
            if (j != 1) wr(SYNC, 1);
            if (j == 0) rd(STAT);
            if (j == 0) chk(d, 32'h0000_0003);
            spin_and_wait(j == 0 ? 2 : 1);
            chk(n_init - k, j != 1);
            chk(nco_phase === OFF, j != 1);
        end
        $display("sysref arming done");
        for (j = 0; j < 2; j++) begin
            @(posedge clk_sys) link_coding <= j[0];
            far.set_sync(1'b0);
            wr(SYNC, 2);
            repeat (4) @(negedge clk_sys);
            chk(link_request_to_link, j);
            spin_and_wait(0);
            chk(n_init - k, 1);
            chk(nco_phase, OFF);
        end
        $display("link request init done");
        @(posedge clk_sys) rst <= 1'b1;
        @(negedge clk_sys) chk(nco_phase, 0);
        @(posedge clk_sys) rst <= 1'b0;
        k = n_init;
        rd(SYNC);
        chk(d, `NCPS_RST_SYNC);
        rd(STAT);
        chk(d, 32'h0000_0001);
        repeat (20) @(posedge clk_sys);
        chk(n_init - k, 0);
        $display("mid-run reset done");
        report_and_stop();
    end
endmodule // nco_phase_sync_and_divisor_tb_top
bind ncps_top ncps_properties u_chk (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .s_axi_awvalid        (s_axi_awvalid),
    .s_axi_awready        (s_axi_awready),
    .s_axi_wvalid         (s_axi_wvalid),
    .s_axi_wready         (s_axi_wready),
    .s_axi_bresp          (s_axi_bresp),
    .s_axi_bvalid         (s_axi_bvalid),
    .s_axi_bready         (s_axi_bready),
    .s_axi_arvalid        (s_axi_arvalid),
    .s_axi_arready        (s_axi_arready),
    .s_axi_rvalid         (s_axi_rvalid),
    .s_axi_rready         (s_axi_rready),
    .link_sync_n          (link_sync_n),
    .sysref               (sysref),
    .link_coding          (link_coding),
    .frame_boundary       (frame_boundary),
    .link_request_to_link (link_request_to_link),
    .phase_init_pulse     (phase_init_pulse)
);
`default_nettype wire
